// ---- design/cpu_addr_pkg.sv ----
// Purpose: shared constants and types for the flags and operand addressing block
// Assumes: 8-bit data path, 16-bit address space, 32-bit APB register access
// Notes:   all offsets and flag bit positions live here
package cpu_addr_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] off_condition_flags = 8'h00;    // flags byte
    localparam logic [7:0] off_operand_req     = 8'h04;    // mode, condition, carry, update kind
    localparam logic [7:0] off_operand_data    = 8'h08;    // pc and fetched data
    localparam logic [7:0] off_result          = 8'h0C;    // effective address and next pc
    localparam logic [7:0] off_alu_result      = 8'h10;    // result word to classify

    // ----------------------------------------
    // flag bit positions
    // ----------------------------------------
    localparam int bit_carry    = 0;
    localparam int bit_zero     = 1;
    localparam int bit_negative = 2;
    localparam int bit_mask     = 3;
    localparam int bit_half     = 4;
    localparam int bit_fixed_lo = 5;
    localparam int bit_fixed_hi = 6;
    localparam int bit_overflow = 7;

    // flags after reset: mask set, bits 6 and 5 stuck at one
    localparam logic [7:0] flags_reset = 8'h0068;
    localparam logic [7:0] flags_fixed = 8'h0060;

    // address space
    localparam logic [7:0]  page_zero_high = 8'h00;
    localparam int          mode_count     = 16;
    localparam logic [15:0] pc_step_one    = 16'h0001;

    // ----------------------------------------
    // addressing modes, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        no_operand_mode      = 5'b0_0001,
        branch_offset_mode   = 5'b0_0010,
        literal_operand_mode = 5'b0_0100,
        direct_mode          = 5'b0_1000,
        direct_pair_mode     = 5'b1_0000
    } addr_mode_t;

    // flag update kinds
    typedef enum logic [3:0] {
        upd_none  = 4'h0,
        upd_add   = 4'h1,
        upd_sub   = 4'h2,
        upd_logic = 4'h3,
        upd_move8 = 4'h4,
        upd_move16= 4'h5,
        upd_shift = 4'h6,
        upd_bittst= 4'h7,
        upd_clrmask = 4'h8,
        upd_xfer  = 4'h9,
        upd_setmask = 4'hA
    } flag_upd_t;

    // operand request travelling to the address former
    typedef struct packed {
        addr_mode_t  mode;
        logic [15:0] pc;
        logic [7:0]  byte1;
        logic [7:0]  byte2;
        logic        cond;
    } addr_req_t;

    // address former answer
    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] ea_second;
        logic [15:0] next_pc;
        logic [15:0] literal;
        logic        mem_access;
    } addr_res_t;

endpackage : cpu_addr_pkg

// ---- design/operand_addr_former.sv ----
// Purpose: forms effective addresses and branch targets combinationally
// Assumes: request fields stable for the cycle
// Notes:   pure logic, so no cycles are added to instruction timing
`timescale 1ns/1ps
module operand_addr_former (
    // request
    input  wire cpu_addr_pkg::addr_req_t req,
    // answer
    output cpu_addr_pkg::addr_res_t      res
);
    // ----------------------------------------
    // address arithmetic
    // ----------------------------------------
    logic [15:0] offset_ext;    // sign extended branch offset

    always_comb begin
        offset_ext        = {{8{req.byte1[7]}}, req.byte1}; // RL12 RL13
        res.ea            = 16'h0000;
        res.ea_second     = 16'h0000;
        res.next_pc       = req.pc;
        res.literal       = 16'h0000;
        res.mem_access    = 1'b1;
        case (req.mode)
            cpu_addr_pkg::no_operand_mode: begin
                res.mem_access = 1'b0;  // RL11
            end
            cpu_addr_pkg::branch_offset_mode: begin
                // wraps modulo 64 KB by width
                if (req.cond) begin
                    res.next_pc = req.pc + offset_ext; // RL13 RL19
                end
                res.ea         = req.pc;   // RL7
                res.mem_access = 1'b0;
            end
            cpu_addr_pkg::literal_operand_mode: begin
                res.literal    = {req.byte2, req.byte1}; // RL14
                res.ea         = req.pc;   // RL7
                res.mem_access = 1'b0;
            end
            cpu_addr_pkg::direct_mode: begin
                res.ea = {cpu_addr_pkg::page_zero_high, req.byte1}; // RL15
            end
            cpu_addr_pkg::direct_pair_mode: begin
                res.ea        = {cpu_addr_pkg::page_zero_high, req.byte1}; // RL16
                res.ea_second = res.ea + cpu_addr_pkg::pc_step_one;       // RL16 RL19
            end
            default: begin
                res.mem_access = 1'b0;
            end
        endcase
    end
endmodule : operand_addr_former

// ---- design/flag_eval.sv ----
// Purpose: derives negative, zero and carry from a result
// Assumes: width selects 8 or 16 bit checks
// Notes:   combinational
`timescale 1ns/1ps
module flag_eval (
    // inputs
    input  wire logic [16:0] result,    // bit 16 is carry/borrow out
    input  wire logic        wide,      // 16-bit value
    // outputs
    output logic             neg,
    output logic             zero,
    output logic             carry
);
    // ----------------------------------------
    // classification
    // ----------------------------------------
    always_comb begin
        neg   = wide ? result[15] : result[7];                       // RL2
        zero  = wide ? (result[15:0] == 16'h0000) : (result[7:0] == 8'h00); // RL3
        // carry or borrow always travels in bit 16, whatever the width
        carry = result[16];                                          // RL4
    end
endmodule : flag_eval

// ---- design/cpu_flags_and_operand_addressing.sv ----
// Purpose: condition flags and operand addressing for an 8-bit cpu, APB view
// Assumes: one clock, async active-low reset, APB master keeps requests stable
// Notes:   address forming is combinational and adds no cycles
//
// What this block does
// RL1: no interrupt right after mask-clear or transfer
// RL2: negative follows top bit of result
// RL3: zero set when result all zeros
// RL4: carry on add carry-out or subtract borrow
// RL5: bit-test, shift, rotate also update carry
// RL6: one shared 64 KB address space
// RL7: non-inherent modes yield 16-bit address
// RL8: address forming adds no cycles
// RL9: sixteen addressing modes overall; this block forms five
// RL10: test operand by mode, relative branch after
// RL11: inherent mode performs no memory access
// RL12: relative offset is signed byte after opcode
// RL13: taken branch adds sign-extended offset to pc
// RL14: immediate bytes are the operand value
// RL15: direct address high byte is zero
// RL16: pair access high byte at lower address
// RL17: flag bits 6 and 5 read one
// RL18: interrupt entry sets mask before handler
// RL19: address arithmetic wraps modulo 65536
`timescale 1ns/1ps
module cpu_flags_and_operand_addressing (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // interrupt boundary
    input  wire logic        irq_pending,   // maskable request from the system
    input  wire logic        insn_boundary, // one-cycle pulse at end of an instruction
    input  wire logic        irq_stacked,   // pulse: registers saved on stack
    output logic             irq_take,      // service allowed at this boundary
    // addressing results
    output logic [15:0]      eff_addr,      // RL6 RL7
    output logic             mem_access,
    output logic [7:0]       flags_out
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic        wr_cycle;              // write accepted this edge
    logic        rd_cycle;              // read accepted this edge
    logic        addr_ok;               // mapped offset

    assign pready   = 1'b1;             // zero wait states
    assign wr_cycle = psel && penable && pwrite;
    assign rd_cycle = psel && penable && !pwrite;
    assign addr_ok  = (paddr == cpu_addr_pkg::off_condition_flags) ||
                      (paddr == cpu_addr_pkg::off_operand_req) ||
                      (paddr == cpu_addr_pkg::off_operand_data) ||
                      (paddr == cpu_addr_pkg::off_result) ||
                      (paddr == cpu_addr_pkg::off_alu_result);
    assign pslverr  = psel && penable && !addr_ok;

    // ----------------------------------------
    // software-held state
    // ----------------------------------------
    logic [7:0]  flags;                 // condition_flags storage
    cpu_addr_pkg::addr_mode_t  mode;    // operand request mode
    cpu_addr_pkg::flag_upd_t   upd;     // flag update kind
    logic        cond;                  // branch condition holds
    logic [15:0] pc;                    // pc after operand bytes
    logic [7:0]  byte1;                 // first byte after opcode
    logic [7:0]  byte2;                 // second byte
    logic [16:0] alu_res;               // result with carry out
    logic        shift_carry;           // carry defined by shift/bit test
    logic        hold_irq;              // defer service one instruction

    // ----------------------------------------
    // address forming, no added cycles
    // ----------------------------------------
    cpu_addr_pkg::addr_req_t req;
    cpu_addr_pkg::addr_res_t res;

    assign req.mode  = mode;
    assign req.pc    = pc;
    assign req.byte1 = byte1;
    assign req.byte2 = byte2;
    assign req.cond  = cond;

    operand_addr_former u_former (   // RL8 RL9
        .req (req),
        .res (res)
    );

    assign eff_addr   = res.ea;
    assign mem_access = res.mem_access; // RL11

    // ----------------------------------------
    // result classification
    // ----------------------------------------
    logic n_f;
    logic z_f;
    logic c_f;

    // classify the word being written, so the flags follow this
    // result and not the one held from the previous write
    flag_eval u_eval (
        .result (pwdata[16:0]),
        .wide   (upd == cpu_addr_pkg::upd_move16),
        .neg    (n_f),
        .zero   (z_f),
        .carry  (c_f)
    );

    // ----------------------------------------
    // operand request registers
    // ----------------------------------------
    // write to request word: [4:0] mode, [8] cond, [15:12] update kind
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode  <= cpu_addr_pkg::no_operand_mode;
            cond  <= 1'b0;
            upd   <= cpu_addr_pkg::upd_none;
            shift_carry <= 1'b0;
        end else if (wr_cycle && paddr == cpu_addr_pkg::off_operand_req) begin
            mode  <= cpu_addr_pkg::addr_mode_t'(pwdata[4:0]); // RL10
            cond  <= pwdata[8];                               // RL10
            shift_carry <= pwdata[9];                         // RL5
            upd   <= cpu_addr_pkg::flag_upd_t'(pwdata[15:12]);
        end
    end

    // data word: [15:0] pc, [23:16] byte1, [31:24] byte2
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc    <= 16'h0000;
            byte1 <= 8'h00;
            byte2 <= 8'h00;
        end else if (wr_cycle && paddr == cpu_addr_pkg::off_operand_data) begin
            pc    <= pwdata[15:0];
            byte1 <= pwdata[23:16];
            byte2 <= pwdata[31:24];
        end
    end

    // result word to classify, bit 16 carry or borrow out
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alu_res <= 17'h0_0000;
        end else if (wr_cycle && paddr == cpu_addr_pkg::off_alu_result) begin
            alu_res <= pwdata[16:0];
        end
    end

    // ----------------------------------------
    // flag register
    // ----------------------------------------
    // writing the result word applies the staged update kind;
    // direct flag write acts as a transfer into the flags
    logic flag_apply;
    assign flag_apply = wr_cycle && paddr == cpu_addr_pkg::off_alu_result;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flags <= cpu_addr_pkg::flags_reset;
        end else if (irq_stacked) begin
            flags[cpu_addr_pkg::bit_mask] <= 1'b1;                  // RL18
        end else if (wr_cycle && paddr == cpu_addr_pkg::off_condition_flags) begin
            flags <= pwdata[7:0] | cpu_addr_pkg::flags_fixed;        // RL17
        end else if (flag_apply) begin
            case (upd)
                cpu_addr_pkg::upd_add, cpu_addr_pkg::upd_sub: begin
                    flags[cpu_addr_pkg::bit_negative] <= n_f;        // RL2
                    flags[cpu_addr_pkg::bit_zero]     <= z_f;        // RL3
                    flags[cpu_addr_pkg::bit_carry]    <= c_f;        // RL4
                end
                cpu_addr_pkg::upd_logic, cpu_addr_pkg::upd_move8,
                cpu_addr_pkg::upd_move16: begin
                    flags[cpu_addr_pkg::bit_negative] <= n_f;        // RL2
                    flags[cpu_addr_pkg::bit_zero]     <= z_f;        // RL3
                end
                cpu_addr_pkg::upd_shift: begin
                    flags[cpu_addr_pkg::bit_negative] <= n_f;
                    flags[cpu_addr_pkg::bit_zero]     <= z_f;
                    flags[cpu_addr_pkg::bit_carry]    <= shift_carry; // RL5
                end
                cpu_addr_pkg::upd_bittst: begin
                    flags[cpu_addr_pkg::bit_carry]    <= shift_carry; // RL5
                end
                cpu_addr_pkg::upd_clrmask: begin
                    flags[cpu_addr_pkg::bit_mask]     <= 1'b0;
                end
                cpu_addr_pkg::upd_setmask: begin
                    flags[cpu_addr_pkg::bit_mask]     <= 1'b1;
                end
                cpu_addr_pkg::upd_xfer: begin
                    flags <= pwdata[7:0] | cpu_addr_pkg::flags_fixed; // RL17
                end
                default: begin
                    flags <= flags;
                end
            endcase
        end
    end

    assign flags_out = flags;

    // ----------------------------------------
    // interrupt deferral
    // ----------------------------------------
    // a mask clear or transfer arms the hold; the next two boundaries
    // pass without service so one instruction always runs
    logic mask_clear_evt;
    assign mask_clear_evt = (flag_apply && (upd == cpu_addr_pkg::upd_clrmask ||
                                            upd == cpu_addr_pkg::upd_xfer)) ||
                            (wr_cycle && paddr == cpu_addr_pkg::off_condition_flags);

    logic hold_used;                    // boundary of the shielding instruction seen
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hold_irq  <= 1'b0;
            hold_used <= 1'b0;
        end else if (mask_clear_evt) begin
            hold_irq  <= 1'b1;          // RL1, set wins over release
            hold_used <= 1'b0;
        end else if (hold_irq && insn_boundary) begin
            // first boundary ends the mask instruction, second the next one
            if (hold_used) begin
                hold_irq <= 1'b0;       // RL1
            end
            hold_used <= 1'b1;
        end
    end

    assign irq_take = irq_pending && insn_boundary && !hold_irq &&
                      !flags[cpu_addr_pkg::bit_mask]; // RL1

    // ----------------------------------------
    // read mux, registered data
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                cpu_addr_pkg::off_condition_flags: prdata <= {24'h00_0000, flags};
                cpu_addr_pkg::off_operand_req:
                    prdata <= {16'h0000, upd, 2'b00, shift_carry, cond, 3'b000, mode};
                cpu_addr_pkg::off_operand_data: prdata <= {byte2, byte1, pc};
                cpu_addr_pkg::off_result:       prdata <= {res.next_pc, res.ea};
                cpu_addr_pkg::off_alu_result:   prdata <= {15'h0000, alu_res};
                default:                        prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : cpu_flags_and_operand_addressing

// ---- verif/flags_addr_chk.sv ----
// Purpose: concurrent checks on the flags and addressing block ports
// Assumes: apb write lands at the access edge, pready sampled there
// Notes:   mode and update kind are shadowed from apb writes
`timescale 1ns/1ps
module flags_addr_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // interrupt boundary
    input wire logic        irq_pending,
    input wire logic        insn_boundary,
    input wire logic        irq_stacked,
    input wire logic        irq_take,
    // addressing
    input wire logic [15:0] eff_addr,
    input wire logic        mem_access,
    input wire logic [7:0]  flags_out
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [4:0] mode_q;  // last mode written
    logic [3:0] kind_q;  // last update kind written
    wire        wr_acc = psel && penable && pwrite && pready;  // write takes effect
    wire  [7:0] wr_b1  = pwdata[23:16];  // direct low byte
    wire        wr_n   = pwdata[7];      // byte top bit
    wire        wr_z   = pwdata[7:0] == 8'h00;
    wire        wr_c   = pwdata[16];     // carry out
    // shadow of the request register, cleared with the design
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 5'h01;
            kind_q <= 4'h0;
        end else if (wr_acc && paddr == cpu_addr_pkg::off_operand_req) begin
            mode_q <= pwdata[4:0];
            kind_q <= pwdata[15:12];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_fixed_bits: assert property (flags_out[6:5] == 2'h3) else $error("fixed flag bits not one");
    a_stack_mask: assert property (irq_stacked |=> flags_out[3]) else $error("mask not set on entry");
    a_take_cause: assert property (irq_take |-> irq_pending && insn_boundary && !flags_out[3])
        else $error("service taken without cause");
    a_clear_hold: assert property ($fell(flags_out[3]) |-> !irq_take) else $error("service right after unmask");
    a_inh_nomem: assert property (mode_q == 5'h01 |-> !mem_access) else $error("inherent mode accessed memory");
    a_direct_page: assert property (mode_q == 5'h08 |-> mem_access && eff_addr[15:8] == 8'h00)
        else $error("direct address off page zero");
    a_addr_nowait: assert property (wr_acc && paddr == cpu_addr_pkg::off_operand_data
        && (mode_q == 5'h08 || mode_q == 5'h10) |=> eff_addr == {8'h00, $past(wr_b1)})
        else $error("direct address late or wrong");
    a_move_nz: assert property (wr_acc && paddr == cpu_addr_pkg::off_alu_result && kind_q == 4'h4
        |=> flags_out[2] == $past(wr_n) && flags_out[1] == $past(wr_z)) else $error("load flags wrong");
    a_add_carry: assert property (wr_acc && paddr == cpu_addr_pkg::off_alu_result && kind_q == 4'h1
        |=> flags_out[0] == $past(wr_c)) else $error("add carry wrong");
    // main scenarios reached
    c_take: cover property (irq_take);
    c_result: cover property (wr_acc && paddr == cpu_addr_pkg::off_alu_result);
    c_refused: cover property (psel && penable && pslverr);
endmodule : flags_addr_chk

bind cpu_flags_and_operand_addressing flags_addr_chk u_chk (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .irq_pending(irq_pending), .insn_boundary(insn_boundary), .irq_stacked(irq_stacked),
    .irq_take(irq_take), .eff_addr(eff_addr), .mem_access(mem_access), .flags_out(flags_out));

// ---- verif/shared_mem_model.sv ----
// Purpose: far-side model of the shared 64 KB memory and i/o space
// Assumes: eff_addr and mem_access settle within a cycle
// Notes:   word answer puts the lower address in the high byte
`timescale 1ns/1ps
module shared_mem_model (
    // clock
    input  wire logic        clock,
    // address side
    input  wire logic [15:0] eff_addr,
    input  wire logic        mem_access,
    // data side
    output logic      [15:0] rd_word
);
    // one flat map: ram, registers and ports answer alike
    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : byte_at
    initial rd_word = 16'h0000;
    // idle: lines toggle so a stale word never passes for an answer
    always @(posedge clock) begin
        if (mem_access) rd_word <= {byte_at(eff_addr), byte_at(eff_addr + 16'h0001)};
        else rd_word <= ~rd_word;
    end
endmodule : shared_mem_model

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for flags and operand addressing
// Assumes: zero-wait apb slave, boundary and stack pulses from the bench
// Notes:   driver queues expectations, monitor compares on each answer
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
    // expected read: error, data, care mask, mem_access check
    typedef struct packed {logic err; logic [31:0] data; logic [31:0] care; logic [1:0] ma;} rd_t;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        irq_pending, insn_boundary, irq_stacked, irq_take, mem_access;
    logic [7:0]  paddr, flags_out;
    logic [31:0] pwdata, prdata;
    logic [15:0] eff_addr, mem_word;
    logic [31:0] lfsr_q = 32'h3f2a_e018;  // random source state
    rd_t         rq[$];                   // pending read expectations
    logic        iq[$];                   // pending boundary expectations
    int          bad_count = 0;
    int          n_checks = 0;
    cpu_flags_and_operand_addressing dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .irq_pending(irq_pending), .insn_boundary(insn_boundary), .irq_stacked(irq_stacked),
        .irq_take(irq_take), .eff_addr(eff_addr), .mem_access(mem_access), .flags_out(flags_out));
    shared_mem_model mem (.clock(clock), .eff_addr(eff_addr), .mem_access(mem_access), .rd_word(mem_word));
    // lfsr stepped a full word per call to decorrelate values
    function logic [31:0] rnd();
        repeat (32) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd
    task results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // one apb transfer, held until pready seen high
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready) break;
        end
        if (i == 16) begin
            bad_count++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic e, input logic [31:0] d, input logic [31:0] c, input logic [1:0] m);
        rq.push_back(rd_t'({e, d, c, m}));
        apb(a, 1'b0, 32'h0000_0000);
    endtask : rd
    task bnd(input logic e);
        iq.push_back(e);
        @(posedge clock);
        insn_boundary <= 1'b1;
        @(posedge clock);
        insn_boundary <= 1'b0;
    endtask : bnd
    // monitor: compares each answer with the oldest expectation
    always @(posedge clock) begin
        rd_t e;
        logic t;
        if (psel && penable && !pwrite && pready) begin
            e = rq.pop_front();
            `CHK({pslverr, prdata & e.care}, {e.err, e.data & e.care})
            if (e.ma[1]) `CHK(mem_access, e.ma[0])
        end
        if (insn_boundary) begin
            t = iq.pop_front();
            `CHK(irq_take, t)
        end
    end
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        int k, j;
        logic [31:0] r, x, c;
        logic [4:0] m;
        rst_b = 1'b0;
        {psel, penable, pwrite, irq_pending, insn_boundary, irq_stacked} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd(cpu_addr_pkg::off_condition_flags, 0, 32'h0000_0068, 32'hFFFF_FFFF, 2'b00);
        irq_pending <= 1'b1;
        bnd(1'b0);
        // unmask by flags transfer, then by clear-mask update
        for (k = 0; k < 2; k++) begin
            if (k == 0) apb(cpu_addr_pkg::off_condition_flags, 1'b1, 32'h0000_0000);
            else apb(cpu_addr_pkg::off_operand_req, 1'b1, 32'h0000_8001);
            if (k == 1) apb(cpu_addr_pkg::off_alu_result, 1'b1, 32'h0000_0000);
            bnd(1'b0);
            bnd(1'b0);
            bnd(1'b1);
            @(posedge clock);
            irq_stacked <= 1'b1;
            @(posedge clock);
            irq_stacked <= 1'b0;
            rd(cpu_addr_pkg::off_condition_flags, 0, 32'h0000_0068, 32'h0000_0068, 2'b00);
            bnd(1'b0);
        end
        // every update kind except upd_none, zero low result first
        for (k = 1; k < 11; k++) for (j = 0; j < 3; j++) begin
            r = rnd() & ((j == 0) ? 32'h0001_0000 : 32'h0001_FFFF);
            x = rnd() & 32'h0000_0200;
            apb(cpu_addr_pkg::off_operand_req, 1'b1, (k << 12) | x | 32'h0000_0001);
            apb(cpu_addr_pkg::off_alu_result, 1'b1, r);
            c = (k < 3) ? 32'h7 : (k < 6) ? 32'h6 : (k < 8) ? 32'h1 : (k == 9) ? 32'hFF : 32'h8;
            rd(cpu_addr_pkg::off_condition_flags, 0, (k == 9) ? r | 32'h60 : (k == 10) ? 32'h8 :
                {29'h0, (k == 5) ? r[15] : r[7], (k == 5) ? r[15:0] == 16'h0000 : r[7:0] == 8'h00,
                (k > 5) ? x[9] : r[16]}, c, 2'b00);
        end
        // every mode; offset and wrap boundaries on taken branches
        for (j = 0; j < 15; j++) begin
            r = rnd();
            m = 5'h01 << (j % 5);
            if (j == 1) r[23:0] = 24'h80_0010;
            if (j == 11) r[23:0] = 24'h7F_FFF0;
            apb(cpu_addr_pkg::off_operand_req, 1'b1, {23'h0, j[0], 3'h0, m});
            apb(cpu_addr_pkg::off_operand_data, 1'b1, r);
            if (m[3] || m[4]) rd(cpu_addr_pkg::off_result, 0, {r[15:0], 8'h00, r[23:16]}, '1, 2'b11);
            else if (m[1]) rd(cpu_addr_pkg::off_result, 0, {r[15:0] + (j[0] ? {{8{r[23]}}, r[23:16]} : 16'h0),
                r[15:0]}, 32'hFFFF_FFFF, 2'b10);
            else rd(cpu_addr_pkg::off_result, 0, {r[15:0], m[2] ? r[15:0] : 16'h0}, '1, 2'b10);
            if (m[4]) begin
                @(posedge clock);
                x = {16'h0, mem_word};
                apb(cpu_addr_pkg::off_operand_req, 1'b1, 32'h0000_5010);
                apb(cpu_addr_pkg::off_alu_result, 1'b1, x);
                rd(cpu_addr_pkg::off_condition_flags, 0, {29'h0, x[15], x[15:0] == 16'h0000, 1'b0},
                    32'h0000_0006, 2'b00);
            end
        end
        rd(8'h14, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF, 2'b00);
        repeat (2) @(posedge clock);
        results();
    end
endmodule : testbench
